// >>> logic/intc_top.sv
// Vectored interrupt controller with AHB-Lite register slave.
//
// Summary of operation
// RULE_01 - Up to 128 internal and external interrupt sources are collected.
// RULE_02 - Each source has an enable, set via bits or by-number registers.
// RULE_03 - Enable-by-number sets one bit; disable-by-number clears one bit.
// RULE_04 - Enabled asserted source raises normal or fast request per type bit.
// RULE_05 - Only supervisor-mode accesses read or change controller state.
// RULE_06 - Pending fast requests take precedence over all normal requests.
// RULE_07 - Highest level wins; among equal levels the highest source number.
// RULE_08 - Sixteen priority levels per source; level zero is lowest.
// RULE_09 - Levels are programmed through eight priority level registers.
// RULE_10 - A writable mask register masks normal requests by priority.
// RULE_11 - Normal requests at or below the mask level do not assert.
`timescale 1ns/1ps
module intc_top
    import intc_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
)(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [N_SRC-1:0]  irq_src,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [3:0]        hprot,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   irq_normal,
    output logic                   irq_fast
);

    // Sources may come from other clock domains: two-stage synchroniser.
    logic [N_SRC-1:0]        src_meta_r;
    logic [N_SRC-1:0]        src_sync_r;
    logic [N_SRC-1:0]        enable_r;
    logic [N_SRC-1:0]        type_r;
    logic [N_SRC*LVL_W-1:0]  level_r;
    logic [LVL_W-1:0]        mask_r;
    logic                    ctrl_en_r;
    bus_req_t                req_r;
    logic [31:0]             hrdata_r;
    logic                    irq_normal_r;
    logic                    irq_fast_r;
    logic [31:0]             vector_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            src_meta_r <= '0;
            src_sync_r <= '0;
        end else begin
            src_meta_r <= irq_src;
            src_sync_r <= src_meta_r; // RULE_01
        end
    end

    // Active sources split by type.
    logic [N_SRC-1:0] active;
    logic [N_SRC-1:0] pend_fast;
    logic [N_SRC-1:0] pend_norm;
    assign active    = src_sync_r & enable_r;   // RULE_04
    assign pend_fast = active & type_r;         // RULE_04
    assign pend_norm = active & ~type_r;        // RULE_04

    // Priority tree over normal requests; leaves hold level and number.
    localparam int LEAVES = 1 << SRC_W;
    winner_t tree [2*LEAVES-1];

    genvar gi;
    generate
        for (gi = 0; gi < LEAVES; gi++) begin : g_leaf
            if (gi < N_SRC) begin : g_real
                assign tree[LEAVES-1+gi].valid = pend_norm[gi] & ctrl_en_r;
                assign tree[LEAVES-1+gi].level =
                    level_r[gi*LVL_W +: LVL_W]; // RULE_08
                assign tree[LEAVES-1+gi].src = SRC_W'(gi);
            end else begin : g_pad
                assign tree[LEAVES-1+gi] = '0;
            end
        end
        for (gi = 0; gi < LEAVES-1; gi++) begin : g_node
            intc_prio_pick u_pick (
                .lo  (tree[2*gi+1]),
                .hi  (tree[2*gi+2]),
                .win (tree[gi])
            );
        end
    endgenerate

    // Fast requests bypass the tree and the mask entirely.
    logic    fast_any;
    logic    norm_ok;
    winner_t best;
    assign best     = tree[0];
    assign fast_any = ctrl_en_r & (|pend_fast); // RULE_06
    assign norm_ok  = best.valid && (best.level > mask_r); // RULE_11

    // Request outputs are registered to keep the tree off the core's path.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_fast_r   <= 1'b0;
            irq_normal_r <= 1'b0;
        end else begin
            irq_fast_r   <= fast_any;              // RULE_04
            irq_normal_r <= norm_ok && !fast_any;  // RULE_06
        end
    end
    assign irq_fast   = irq_fast_r;
    assign irq_normal = irq_normal_r;

    // Vector word shows the chosen request: fast flag, normal flag,
    // level and number of the best normal request, kept even when a fast request clears the normal flag.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vector_r <= WORD_RST;
        end else begin
            vector_r <= WORD_RST;
            vector_r[VEC_FVALID] <= fast_any;
            vector_r[VEC_NVALID] <= norm_ok && !fast_any; // RULE_06
            vector_r[VEC_LVL_LSB +: LVL_W] <= best.level;
            vector_r[SRC_W-1:0] <= best.src;              // RULE_07
        end
    end

    // Address phase capture; privileged transfers are flagged.
    logic addr_ok;
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ)
                     && (hsize == HSIZE_WORD);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_r <= '0;
        end else if (hready) begin
            req_r.sel   <= addr_ok;
            req_r.write <= hwrite;
            req_r.priv  <= hprot[HPROT_PRIV]; // RULE_05
            req_r.addr  <= haddr[11:0];
        end
    end

    // Write strobe of the data phase; user-mode writes are dropped.
    logic       wr;
    logic [3:0] wsub;
    logic [11:0] wbase;
    assign wr    = req_r.sel && req_r.write && req_r.priv; // RULE_05
    assign wsub  = {1'b0, req_r.addr[4:2]}; // Word inside a 32-byte window.
    assign wbase = {req_r.addr[11:5], 5'h00};

    // Control and mask registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_en_r <= 1'b0;
            mask_r    <= MASK_RST;
        end else if (wr && req_r.addr == OFF_CTRL) begin
            ctrl_en_r <= hwdata[CTRL_EN_BIT];
        end else if (wr && req_r.addr == OFF_MASK) begin
            mask_r <= hwdata[LVL_W-1:0]; // RULE_10
        end
    end

    // Enable bits: word writes plus set and clear by source number.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_r <= '0;
        end else if (wr && wbase == OFF_ENABLE && wsub < 4'(WORDS)) begin
            enable_r[wsub[1:0]*32 +: 32] <= hwdata; // RULE_02
        end else if (wr && req_r.addr == OFF_ENNUM) begin
            if (hwdata < 32'(N_SRC)) begin
                enable_r[hwdata[SRC_W-1:0]] <= 1'b1; // RULE_03
            end
        end else if (wr && req_r.addr == OFF_DISNUM) begin
            if (hwdata < 32'(N_SRC)) begin
                enable_r[hwdata[SRC_W-1:0]] <= 1'b0; // RULE_03
            end
        end
    end

    // Type bits select fast (1) or normal (0) per source.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            type_r <= '0;
        end else if (wr && wbase == OFF_TYPE && wsub < 4'(WORDS)) begin
            type_r[wsub[1:0]*32 +: 32] <= hwdata; // RULE_04
        end
    end

    // Eight level registers, sixteen 4-bit fields in each.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level_r <= '0;
        end else if (wr && wbase == OFF_PRIO && wsub < 4'(PRIO_REGS)) begin
            level_r[wsub[2:0]*(PRIO_PER*LVL_W) +: PRIO_PER*LVL_W]
                <= {2{hwdata}}; // RULE_09
        end
    end

    // Read mux; user-mode reads and holes return zero.
    logic [31:0] rd_nxt;
    logic [1:0]  rw;
    logic [11:0] rbase;
    always_comb begin
        rw     = haddr[3:2];
        rbase  = {haddr[11:5], 5'h00};
        rd_nxt = WORD_RST;
        if (addr_ok && !hwrite && hprot[HPROT_PRIV]) begin // RULE_05
            if (haddr[11:0] == OFF_CTRL) begin
                rd_nxt[CTRL_EN_BIT] = ctrl_en_r;
            end else if (haddr[11:0] == OFF_MASK) begin
                rd_nxt[LVL_W-1:0] = mask_r;
            end else if (haddr[11:0] == OFF_VECTOR) begin
                rd_nxt = vector_r;
            end else if (haddr[4] == 1'b0) begin
                case (rbase)
                    OFF_ENABLE: rd_nxt = enable_r[rw*32 +: 32];
                    OFF_TYPE:   rd_nxt = type_r[rw*32 +: 32];
                    OFF_PEND_N: rd_nxt = pend_norm[rw*32 +: 32];
                    OFF_PEND_F: rd_nxt = pend_fast[rw*32 +: 32];
                    OFF_RAW:    rd_nxt = src_sync_r[rw*32 +: 32];
                    default:    rd_nxt = WORD_RST;
                endcase
            end
            if (rbase == OFF_PRIO) begin
                rd_nxt = level_r[haddr[4:2]*(PRIO_PER*LVL_W) +: 32];
            end
        end
    end

    // Read data registered at the end of an accepted address phase and
    // held through idle cycles, so a late sampler still sees the word.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata_r <= WORD_RST;
        end else if (addr_ok) begin
            hrdata_r <= rd_nxt;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule

// >>> logic/intc_pkg.sv
// Package with register map, field layouts and types of the interrupt controller.
package intc_pkg;

    // Source count, priority width, source number width and register counts.
    localparam int NUM_SRC   = 128;
    localparam int LVL_W     = 4;
    localparam int SRC_W     = 7;
    localparam int WORDS     = NUM_SRC / 32;
    localparam int PRIO_REGS = 8;
    localparam int PRIO_PER  = 16;

    // Byte offsets of the register words.
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_MASK    = 12'h004;
    localparam logic [11:0] OFF_ENNUM   = 12'h008;
    localparam logic [11:0] OFF_DISNUM  = 12'h00C;
    localparam logic [11:0] OFF_VECTOR  = 12'h010;
    localparam logic [11:0] OFF_ENABLE  = 12'h020;
    localparam logic [11:0] OFF_TYPE    = 12'h040;
    localparam logic [11:0] OFF_PRIO    = 12'h060;
    localparam logic [11:0] OFF_PEND_N  = 12'h080;
    localparam logic [11:0] OFF_PEND_F  = 12'h0A0;
    localparam logic [11:0] OFF_RAW     = 12'h0C0;

    // Reset values and field positions.
    localparam logic [LVL_W-1:0] MASK_RST = 4'h0;
    localparam logic [31:0]      WORD_RST = 32'h0000_0000;
    localparam int               CTRL_EN_BIT = 0;
    localparam int               VEC_NVALID  = 31;
    localparam int               VEC_FVALID  = 30;
    localparam int               VEC_LVL_LSB = 8;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam int         HPROT_PRIV    = 1;

    // Result of the normal-request search.
    typedef struct packed {
        logic             valid;
        logic [LVL_W-1:0] level;
        logic [SRC_W-1:0] src;
    } winner_t;

    // Latched address phase of a bus transfer.
    typedef struct packed {
        logic        sel;
        logic        write;
        logic        priv;
        logic [11:0] addr;
    } bus_req_t;

endpackage

// >>> logic/intc_prio_pick.sv
// Compare stage of the priority tree: keeps the higher of two candidates.
`timescale 1ns/1ps
module intc_prio_pick
    import intc_pkg::*;
(
    input  winner_t lo,
    input  winner_t hi,
    output winner_t win
);

    // The upper-numbered candidate wins ties, so equal levels resolve
    // toward the highest source number.
    always_comb begin
        if (!lo.valid) begin
            win = hi;
        end else if (!hi.valid) begin
            win = lo;
        end else if (lo.level > hi.level) begin
            win = lo;
        end else begin
            win = hi; // RULE_07
        end
    end

endmodule

// >>> test/intc_monitor.sv
// Checker of bus answers and request outputs of the interrupt controller.
`timescale 1ns/1ps
module intc_monitor
    import intc_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
)(
    input wire logic             clk,
    input wire logic             reset,
    input wire logic [N_SRC-1:0] irq_src,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [3:0]       hprot,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic             irq_normal,
    input wire logic             irq_fast
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Accepted address phases; read data depends on the one before.
    wire logic acc = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic rd  = acc && !hwrite && hprot[HPROT_PRIV];
    wire logic nrd = acc && !hwrite && !hprot[HPROT_PRIV];

    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready)
        else $error("bus answer not ready or not okay");
    property p_user_rd; nrd |=> hrdata == 32'h0; endproperty
    a_user_rd: assert property (p_user_rd)
        else $error("user mode read returned data");
    property p_hole; rd && haddr[11:0] == 12'h100 |=> hrdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unmapped read returned data");
    property p_hold; !$past(acc) |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without a transfer");
    property p_excl; !(irq_normal && irq_fast); endproperty
    a_excl: assert property (p_excl)
        else $error("normal request beside fast request");
    property p_idle; (irq_src == '0)[*4] |-> !irq_normal && !irq_fast;
    endproperty
    a_idle: assert property (p_idle)
        else $error("request without any source");
    property p_fcause; $rose(irq_fast) |-> $past(irq_src, 3) != '0;
    endproperty
    a_fcause: assert property (p_fcause)
        else $error("fast request without cause");
    property p_ncause; $rose(irq_normal) |-> $past(irq_src, 3) != '0;
    endproperty
    a_ncause: assert property (p_ncause)
        else $error("normal request without cause");
    property p_wake; $fell(reset) |-> !irq_normal && !irq_fast; endproperty
    a_wake: assert property (p_wake)
        else $error("request right after reset");
    // Main scenarios.
    c_fast: cover property ($rose(irq_fast));
    c_norm: cover property ($rose(irq_normal));
    c_user: cover property (nrd);
endmodule

// >>> test/core_model.sv
// Behavioural core that records which request kind it is being offered.
`timescale 1ns/1ps
module core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       irq_normal,
    input  wire logic       irq_fast,
    output logic      [1:0] kind_r
);
    // Bit 1 fast, bit 0 normal; the core samples levels each clock.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            kind_r <= 2'h0;
        end else begin
            kind_r <= {irq_fast, irq_normal};
        end
    end
endmodule

// >>> test/testbench.sv
// Self-checking bench of the interrupt controller.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("[FAIL] %0t %h %h", $time, g, e); end end
module testbench
    import intc_pkg::*;
;
    logic         clk = 0, reset = 1, hsel = 0, hwrite = 0;
    logic [127:0] irq_src = '0;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, rv;
    logic [1:0]   htrans = HTRANS_IDLE, kind;
    logic [3:0]   hprot = 4'h2;
    logic         hreadyout, hresp, irq_normal, irq_fast;
    wire logic    hready = hreadyout;
    int           n_errors = 0, samples_checked = 0, cyc = 0;

    intc_top dut (.clk, .reset, .irq_src, .hsel, .haddr, .htrans, .hwrite,
        .hsize(HSIZE_WORD), .hprot, .hwdata, .hready, .hrdata, .hreadyout,
        .hresp, .irq_normal, .irq_fast);
    core_model core (.clk, .reset, .irq_normal, .irq_fast, .kind_r(kind));

    // Clock and a cycle ceiling that cuts a hang short.
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test;
        end
    end

    // One single word transfer; each phase is held until hready.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] p);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hprot  <= p;
        do @(posedge clk); while (!hready);
        hsel   <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        do @(posedge clk); while (!hready);
        rv = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'h2);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'h2);
        `CHK(rv, e)
    endtask
    // Reads the best-normal word, keeping only its defined fields.
    task automatic vec(input logic [31:0] e);
        xfer(1'b0, OFF_VECTOR, 32'h0, 4'h2);
        `CHK(rv & 32'hC000_0F7F, e)
    endtask
    // Requests follow a source three edges late; four leaves margin.
    // The core's own flop adds one more edge before it sees the kind.
    task automatic irq(input logic [1:0] e);
        repeat (4) @(posedge clk);
        `CHK({irq_fast, irq_normal}, e)
        @(posedge clk);
        `CHK(kind, e)
    endtask

    task automatic t_regs;
        rd(OFF_CTRL, WORD_RST);
        wr(OFF_MASK, 32'h0000_0009);
        rd(OFF_MASK, 32'h0000_0009);
        rd(12'h100, 32'h0);
        wr(OFF_MASK, 32'h0);
        wr(OFF_CTRL, 32'h1);
    endtask
    // User mode may neither change nor see the registers.
    task automatic t_priv;
        xfer(1'b1, OFF_MASK, 32'h7, 4'h0);
        rd(OFF_MASK, 32'h0);
        xfer(1'b0, OFF_CTRL, 32'h0, 4'h0);
        `CHK(rv, 32'h0)
    endtask
    task automatic t_enable;
        wr(OFF_ENNUM, 32'h7F);
        wr(OFF_ENNUM, 32'h3);
        wr(OFF_ENNUM, 32'h5);
        rd(OFF_ENABLE + 12'hC, 32'h8000_0000);
        wr(OFF_DISNUM, 32'h7F);
        rd(OFF_ENABLE + 12'hC, 32'h0);
        rd(OFF_ENABLE, 32'h28);
        wr(OFF_ENABLE + 12'hC, 32'h8000_0000);
        rd(OFF_ENABLE + 12'hC, 32'h8000_0000);
    endtask
    // Source 3 at level 1, source 5 at level 2, then equal levels.
    task automatic t_prio;
        wr(OFF_PRIO, 32'h0020_1000);
        irq_src[3] <= 1'b1;
        irq_src[5] <= 1'b1;
        irq(2'h1);
        vec(32'h8000_0205);
        wr(OFF_PRIO, 32'h0010_1000);
        vec(32'h8000_0105);
        wr(OFF_MASK, 32'h1);
        irq(2'h0);
        wr(OFF_PRIO, 32'h00F0_1000);
        wr(OFF_MASK, 32'hE);
        irq(2'h1);
        wr(OFF_MASK, 32'hF);
        irq(2'h0);
        wr(OFF_MASK, 32'h0);
    endtask
    task automatic t_fast;
        wr(OFF_TYPE, 32'h20);
        irq(2'h2);
        vec(32'h4000_0103);
        irq_src[5] <= 1'b0;
        irq(2'h1);
    endtask
    // Top source number, top level, through the last level register.
    task automatic t_top;
        wr(OFF_PRIO + 12'h1C, 32'hF000_0000);
        irq_src[127] <= 1'b1;
        irq(2'h1);
        vec(32'h8000_0F7F);
        wr(OFF_CTRL, 32'h0);
        irq(2'h0);
    endtask

    task automatic end_of_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_priv;
        t_enable;
        t_prio;
        t_fast;
        t_top;
        end_of_test;
    end
endmodule

bind intc_top intc_monitor #(.N_SRC(N_SRC)) mon (.clk, .reset, .irq_src,
    .hsel, .haddr, .htrans, .hwrite, .hprot, .hready, .hrdata, .hreadyout,
    .hresp, .irq_normal, .irq_fast);
